// ===== peir_params.svh
// constants for the endpoint interrupt request block
`ifndef PEIR_PARAMS_SVH
`define PEIR_PARAMS_SVH
`define PEIR_SEND_CYCLES 4
`define PEIR_INTA_CODE 8'h00
`define PEIR_SEL_ASSERT 1'b0
`define PEIR_SEL_DEASSERT 1'b1
`define PEIR_MME_MAX 3'h5
`define PEIR_MSGNUM_W 5
`define PEIR_REG_CTRL 4'h0
`define PEIR_REG_MSGDATA 4'h1
`define PEIR_REG_STAT 4'h2
`define PEIR_REG_MASK 4'h3
`define PEIR_REG_LAST 4'h4
`define PEIR_REG_STATE 4'h5
`define PEIR_REG_MSGNUM 4'h6
`define PEIR_REG_REQ 4'h7
`endif

// ===== peir_pkg.sv
// types shared by both ends of the interrupt request link
package peir_pkg;
  typedef enum logic [1:0] {
    PEIR_MSG_INTX = 2'h0,
    PEIR_MSG_MSI = 2'h1,
    PEIR_MSG_MSIX = 2'h2
  } peir_msg_type;
  typedef enum logic [2:0] {
    PEIR_DEV_IDLE = 3'b001,
    PEIR_DEV_SEND = 3'b010,
    PEIR_DEV_GRANT = 3'b100
  } peir_dev_state_type;
  typedef enum logic [2:0] {
    PEIR_USR_IDLE = 3'b001,
    PEIR_USR_WAIT = 3'b010,
    PEIR_USR_DONE = 3'b100
  } peir_usr_state_type;
endpackage

// ===== peir_if.sv
// interrupt request link between user logic and the endpoint
`timescale 1ns/100ps
`default_nettype none
interface peir_if;
  logic irq_req;
  logic irq_grant;
  logic irq_deassert_sel;
  logic [7:0] irq_vector_in;
  logic [7:0] irq_msg_data_lo;
  logic [2:0] irq_mm_enable;
  logic irq_msi_en;
  logic irq_msix_en;
  logic irq_msix_fmask;
  logic [4:0] irq_msg_num;
  logic irq_status_in;
  modport dev (
    input irq_req, irq_deassert_sel, irq_vector_in, irq_msg_num, irq_status_in,
    output irq_grant, irq_msg_data_lo, irq_mm_enable, irq_msi_en, irq_msix_en,
    output irq_msix_fmask
  );
  modport usr (
    output irq_req, irq_deassert_sel, irq_vector_in, irq_msg_num, irq_status_in,
    input irq_grant, irq_msg_data_lo, irq_mm_enable, irq_msi_en, irq_msix_en,
    input irq_msix_fmask
  );
endinterface
`default_nettype wire

// ===== peir_device.sv
// endpoint end: grants interrupt requests and emits message strobes
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "peir_params.svh"
// Summary of operation
// - request causes message of selected type
// - user holds request until grant
// - grant with request means message sent
// - select 0 asserts, 1 deasserts INTx
// - vector in low bits per MME
// - legacy supports INTA only, code 00h
// - output low byte of MSI data
// - output MME field, 000b to 101b
// - output MSI enabled flag
// - output MSI-X enabled flag
// - output MSI-X function mask
// - message number loaded from user input
// - user corrects invalid message number
// - status bit follows input when auto off
module peir_device
  import peir_pkg::*;
#(
  parameter int SEND_CYCLES = `PEIR_SEND_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  peir_if.dev link,
  // host-side configuration, as written into config space
  input wire logic [2:0] cfg_mm_enable_i,
  input wire logic cfg_msi_en_i,
  input wire logic cfg_msix_en_i,
  input wire logic cfg_msix_fmask_i,
  input wire logic [15:0] cfg_msi_data_i,
  input wire logic auto_status_en_i,
  // transmitted message report
  output logic msg_valid_o,
  output peir_msg_type msg_type_o,
  output logic msg_deassert_o,
  output logic [7:0] msg_data_o,
  output logic [4:0] cap_msg_num_o,
  output logic int_status_o
);
  // ==========================================================
  // state and constants
  typedef struct packed {
    peir_dev_state_type state;
    logic [7:0] count;
    logic msg_valid;
    peir_msg_type msg_type;
    logic msg_deassert;
    logic [7:0] msg_data;
    logic [4:0] msg_num;
    logic int_status;
    logic [7:0] data_lo;
    logic [2:0] mme;
    logic msi_en;
    logic msix_en;
    logic fmask;
  } peir_dev_type;

  // a zero count would wrap the down-counter, keep SEND_CYCLES at one or more
  localparam logic [7:0] SEND_LOAD = 8'(SEND_CYCLES - 1);

  // every field written out so a new field cannot slip past reset
  localparam peir_dev_type DEV_RESET = '{
    state: PEIR_DEV_IDLE,
    count: '0,
    msg_valid: '0,
    msg_type: PEIR_MSG_INTX,
    msg_deassert: '0,
    msg_data: '0,
    msg_num: '0,
    int_status: '0,
    data_lo: '0,
    mme: '0,
    msi_en: '0,
    msix_en: '0,
    fmask: '0
  };

  peir_dev_type r;
  peir_dev_type next_r;

  // ==========================================================
  // message building
  // merge vector bits into message data per multiple message enable
  function automatic logic [7:0] peir_merge(input logic [7:0] base, input logic [7:0] vec,
                                            input logic [2:0] mme);
    logic [7:0] m;
    m = 8'h00;
    if (mme <= `PEIR_MME_MAX) begin
      m = 8'((9'h001 << mme) - 9'h001);
    end
    return (base & ~m) | (vec & m);
  endfunction

  typedef struct packed {
    peir_msg_type kind;
    logic deassert;
    logic [7:0] data;
  } peir_msg_rec_type;

  peir_msg_rec_type msg;

  // contents fixed from the enables held in the last send cycle; msi-x outranks msi
  function automatic peir_msg_rec_type peir_build_msg(input logic msix_en,
                                                      input logic msi_en,
                                                      input logic [7:0] data_lo,
                                                      input logic [2:0] mme,
                                                      input logic [7:0] vec,
                                                      input logic sel);
    peir_msg_rec_type m;
    m.kind = PEIR_MSG_INTX;
    m.deassert = 1'b0;
    m.data = `PEIR_INTA_CODE;
    if (msix_en) begin
      m.kind = PEIR_MSG_MSIX;
      m.data = vec;
    end else if (msi_en) begin
      m.kind = PEIR_MSG_MSI;
      m.data = peir_merge(data_lo, vec, mme);
    end else begin
      m.deassert = (sel == `PEIR_SEL_DEASSERT);
    end
    return m;
  endfunction

  // legacy assert raises the status bit, deassert drops it; msi leaves it alone
  function automatic logic peir_auto_status(input logic cur, input peir_msg_type kind,
                                            input logic sel);
    logic s;
    s = cur;
    if (kind == PEIR_MSG_INTX) begin
      s = (sel == `PEIR_SEL_ASSERT);
    end
    return s;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    msg = peir_build_msg(r.msix_en, r.msi_en, r.data_lo, r.mme, link.irq_vector_in,
                         link.irq_deassert_sel);
    next_r.msg_valid = 1'b0;
    next_r.data_lo = cfg_msi_data_i[7:0];
    next_r.mme = cfg_mm_enable_i;
    next_r.msi_en = cfg_msi_en_i;
    next_r.msix_en = cfg_msix_en_i;
    next_r.fmask = cfg_msix_fmask_i;
    next_r.msg_num = link.irq_msg_num;
    if (!auto_status_en_i) begin
      next_r.int_status = link.irq_status_in;
    end
    case (r.state)
      PEIR_DEV_IDLE: begin
        if (link.irq_req) begin
          next_r.state = PEIR_DEV_SEND;
          next_r.count = SEND_LOAD;
        end
      end
      PEIR_DEV_SEND: begin
        // request inputs sampled stable while the message is serialised
        if (r.count == 8'h00) begin
          next_r.state = PEIR_DEV_GRANT;
          next_r.msg_valid = 1'b1;
          next_r.msg_type = msg.kind;
          next_r.msg_deassert = msg.deassert;
          next_r.msg_data = msg.data;
          if (auto_status_en_i) begin
            next_r.int_status = peir_auto_status(r.int_status, msg.kind, link.irq_deassert_sel);
          end
        end else begin
          next_r.count = r.count - 8'h01;
        end
      end
      PEIR_DEV_GRANT: begin
        next_r.state = PEIR_DEV_IDLE;
      end
      default: begin
        next_r.state = PEIR_DEV_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= DEV_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  // grant only while the request is still held, one cycle
  assign link.irq_grant = (r.state == PEIR_DEV_GRANT) && link.irq_req;
  assign link.irq_msg_data_lo = r.data_lo;
  assign link.irq_mm_enable = r.mme;
  assign link.irq_msi_en = r.msi_en;
  assign link.irq_msix_en = r.msix_en;
  assign link.irq_msix_fmask = r.fmask;
  assign msg_valid_o = r.msg_valid;
  assign msg_type_o = r.msg_type;
  assign msg_deassert_o = r.msg_deassert;
  assign msg_data_o = r.msg_data;
  assign cap_msg_num_o = r.msg_num;
  assign int_status_o = r.int_status;
endmodule
`default_nettype wire

// ===== peir_user.sv
// user end: register-driven interrupt requester
`timescale 1ns/100ps
`default_nettype none
`include "peir_params.svh"
module peir_user
  import peir_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  peir_if.usr link,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  typedef struct packed {
    peir_usr_state_type state;
    logic deassert_sel;
    logic [7:0] vector;
    logic [4:0] msg_num;
    logic status_in;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
  } peir_usr_type;

  peir_usr_type r;
  peir_usr_type next_r;
  logic [4:0] vec_bits;

  always_comb begin
    vec_bits = {2'b00, link.irq_mm_enable};
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    // ==========================================================
    // register writes; set beats clear on status
    if (wr_i) begin
      if (addr_i == `PEIR_REG_CTRL) begin
        next_r.deassert_sel = wdata_i[8];
        next_r.status_in = wdata_i[9];
        next_r.vector = wdata_i[7:0];
      end else if (addr_i == `PEIR_REG_MSGNUM) begin
        next_r.msg_num = wdata_i[4:0];
      end else if (addr_i == `PEIR_REG_STAT) begin
        next_r.stat = r.stat & ~wdata_i[1:0];
      end else if (addr_i == `PEIR_REG_MASK) begin
        next_r.mask = wdata_i[1:0];
      end else if (addr_i == `PEIR_REG_REQ) begin
        if (wdata_i[0] && r.state != PEIR_USR_WAIT) begin
          next_r.state = PEIR_USR_WAIT;
        end else if (wdata_i[0]) begin
          // a second request while one waits is dropped and flagged
          next_r.stat[1] = 1'b1;
        end
      end
    end
    // ==========================================================
    // request handshake
    case (r.state)
      PEIR_USR_IDLE: begin
      end
      PEIR_USR_WAIT: begin
        if (link.irq_grant) begin
          next_r.state = PEIR_USR_DONE;
          next_r.stat[0] = 1'b1;
        end
      end
      PEIR_USR_DONE: begin
        if (!(wr_i && addr_i == `PEIR_REG_REQ && wdata_i[0])) begin
          next_r.state = PEIR_USR_IDLE;
        end
      end
      default: begin
        next_r.state = PEIR_USR_IDLE;
      end
    endcase
    // keep message number valid under reduced vector count; applied to the value
    // about to be stored so a software write never shows an invalid number
    if (link.irq_msi_en && !link.irq_msix_en && link.irq_mm_enable <= `PEIR_MME_MAX &&
        (next_r.msg_num >> vec_bits) != 5'h00) begin
      next_r.msg_num = next_r.msg_num & 5'((6'h01 << vec_bits) - 6'h01);
    end
    // ==========================================================
    // reads
    if (rd_i) begin
      if (addr_i == `PEIR_REG_CTRL) begin
        next_r.rdata = {22'h0, r.status_in, r.deassert_sel, r.vector};
      end else if (addr_i == `PEIR_REG_MSGDATA) begin
        next_r.rdata = {21'h0, link.irq_msix_fmask, link.irq_msix_en, link.irq_msi_en,
                        link.irq_mm_enable, link.irq_msg_data_lo[7:3]};
      end else if (addr_i == `PEIR_REG_STAT) begin
        next_r.rdata = {30'h0, r.stat};
      end else if (addr_i == `PEIR_REG_MASK) begin
        next_r.rdata = {30'h0, r.mask};
      end else if (addr_i == `PEIR_REG_LAST) begin
        next_r.rdata = {24'h0, link.irq_msg_data_lo};
      end else if (addr_i == `PEIR_REG_STATE) begin
        next_r.rdata = {29'h0, r.state};
      end else if (addr_i == `PEIR_REG_MSGNUM) begin
        next_r.rdata = {27'h0, r.msg_num};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '{state: PEIR_USR_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // select and vector come from flops, stable across the request unless CTRL is written while it waits
  assign link.irq_req = (r.state == PEIR_USR_WAIT);
  assign link.irq_deassert_sel = r.deassert_sel;
  assign link.irq_vector_in = r.vector;
  assign link.irq_msg_num = r.msg_num;
  assign link.irq_status_in = r.status_in;
  assign rdata_o = r.rdata;
  assign irq_o = |(r.stat & r.mask);
endmodule
`default_nettype wire

// ===== peir_link_properties.sv
// checker for the interrupt request link between the two ends
`timescale 1ns/100ps
`default_nettype none
module peir_link_check #(
  parameter int SEND_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic irq_req,
  input wire logic irq_grant,
  input wire logic irq_deassert_sel,
  input wire logic [7:0] irq_vector_in,
  input wire logic [2:0] irq_mm_enable,
  input wire logic irq_msi_en,
  input wire logic irq_msix_en,
  input wire logic [4:0] irq_msg_num
);
  logic [7:0] wait_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // cycles the request has been standing, zero while idle
  always_ff @(posedge clk_i) begin
    wait_cnt <= (reset_i || !irq_req) ? 8'h00 : wait_cnt + 8'h01;
  end
  // ==========
  // properties
  property p_grant_req; irq_grant |-> irq_req; endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
  property p_req_hold; irq_req && !irq_grant |=> irq_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_drop; irq_grant |=> !irq_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after grant");
  property p_args; irq_req && !irq_grant |=> $stable(irq_deassert_sel) && $stable(irq_vector_in);
  endproperty
  a_args: assert property (p_args) else $error("request arguments moved");
  property p_grant_time; irq_grant |-> wait_cnt == SEND_CYCLES + 1; endproperty
  a_grant_time: assert property (p_grant_time) else $error("grant at wrong cycle");
  property p_grant_bound; irq_req |-> wait_cnt <= SEND_CYCLES + 1; endproperty
  a_grant_bound: assert property (p_grant_bound) else $error("request never served");
  property p_grant_once; irq_grant |=> !irq_grant; endproperty
  a_grant_once: assert property (p_grant_once) else $error("grant longer than one cycle");
  property p_mme; irq_mm_enable <= 3'h5 && irq_mm_enable != 3'h3; endproperty
  a_mme: assert property (p_mme) else $error("illegal vector field");
  property p_num_fit;
    (irq_msi_en && !irq_msix_en && $stable(irq_mm_enable)) [*3] |-> (irq_msg_num >> irq_mm_enable) == 5'h00;
  endproperty
  a_num_fit: assert property (p_num_fit) else $error("message number out of range");
endmodule
`default_nettype wire

// ===== tb_top.sv
// testbench joining the requester and the endpoint end
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import peir_pkg::*;
  localparam int SC = 4;
  logic clk_i, reset_i, wr_i, rd_i, irq_o, msg_valid_o, msg_deassert_o, int_status_o;
  logic cfg_msi_en_i, cfg_msix_en_i, cfg_msix_fmask_i, auto_status_en_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [2:0] cfg_mm_enable_i;
  logic [15:0] cfg_msi_data_i;
  logic [7:0] msg_data_o, vec, dm;
  logic [4:0] cap_msg_num_o;
  peir_msg_type msg_type_o;
  int fails = 0, n_checks = 0, seed;
  int q[$];
  int mmes[8] = '{0, 0, 0, 1, 2, 4, 5, 0};
  peir_if lnk();
  peir_device #(.SEND_CYCLES(SC)) peir_device_i (.clk_i(clk_i), .reset_i(reset_i), .link(lnk),
    .cfg_mm_enable_i(cfg_mm_enable_i), .cfg_msi_en_i(cfg_msi_en_i), .cfg_msix_en_i(cfg_msix_en_i),
    .cfg_msix_fmask_i(cfg_msix_fmask_i), .cfg_msi_data_i(cfg_msi_data_i),
    .auto_status_en_i(auto_status_en_i), .msg_valid_o(msg_valid_o), .msg_type_o(msg_type_o),
    .msg_deassert_o(msg_deassert_o), .msg_data_o(msg_data_o), .cap_msg_num_o(cap_msg_num_o),
    .int_status_o(int_status_o));
  peir_user peir_user_i (.clk_i(clk_i), .reset_i(reset_i), .link(lnk), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  peir_link_check #(.SEND_CYCLES(SC)) peir_link_check_i (.clk_i(clk_i), .reset_i(reset_i),
    .irq_req(lnk.irq_req), .irq_grant(lnk.irq_grant), .irq_deassert_sel(lnk.irq_deassert_sel),
    .irq_vector_in(lnk.irq_vector_in), .irq_mm_enable(lnk.irq_mm_enable),
    .irq_msi_en(lnk.irq_msi_en), .irq_msix_en(lnk.irq_msix_en), .irq_msg_num(lnk.irq_msg_num));
  // ==========
  // tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", e, rdata_o);
  endtask
  // bounded wait, the message pulse stands one cycle only
  task wait_msg;
    for (int i = 0; i < 20 && msg_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("valid", 1, msg_valid_o);
  endtask
  task print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========
  // clock, watchdog, sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    print_verdict();
  end
  initial begin
    seed = 32'he7e5301b;
    {reset_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 38'h0};
    {cfg_msi_en_i, cfg_msix_en_i, cfg_msix_fmask_i, cfg_mm_enable_i} = 6'h00;
    auto_status_en_i = 1'b1;
    cfg_msi_data_i = 16'h5a3c;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(4'h2, 0);
    rd(4'h8, 0);
    rd(4'h4, 32'h3c);
    wr(4'h3, 1);
    // modes: INTx assert, INTx deassert, MSI at field values 0, 1, 2, 4 and 5, MSI-X
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_i);
      cfg_msix_en_i <= (m == 7);
      cfg_msi_en_i <= (m > 1 && m < 7);
      cfg_mm_enable_i <= mmes[m][2:0];
      cfg_msix_fmask_i <= m[0];
      repeat (3) @(posedge clk_i);
      #1;
      chk("cfg", {m == 7, m > 1 && m < 7, m[0], mmes[m][2:0], 8'h3c}, {lnk.irq_msix_en,
        lnk.irq_msi_en, lnk.irq_msix_fmask, lnk.irq_mm_enable, lnk.irq_msg_data_lo});
      rd(4'h1, {21'h0, m[0], m == 7, m > 1 && m < 7, mmes[m][2:0], 5'h07});
      vec = 8'($random(seed));
      dm = 8'((1 << mmes[m]) - 1);
      if (m < 7) q.push_back(m < 2 ? 0 : (8'h3c & ~dm) | (vec & dm));
      wr(4'h0, {23'h0, m == 1, vec});
      wr(4'h7, 1);
      wait_msg();
      chk("type", m == 7 ? 2 : m > 1 ? 1 : 0, msg_type_o);
      if (m < 7) chk("data", q.pop_front(), msg_data_o);
      if (m < 2) chk("sel", m, msg_deassert_o);
      if (m < 2) chk("auto", m == 0, int_status_o);
      @(posedge clk_i);
      #1;
      chk("irq", 1, irq_o);
      wr(4'h2, 1);
      #1;
      chk("irq", 0, irq_o);
      wr(4'h6, 32'h1f);
      repeat (3) @(posedge clk_i);
      #1;
      chk("msgnum", (m > 1 && m < 7) ? 32'h1f & dm : 32'h1f, cap_msg_num_o);
      $display("test mode %0d done", m);
    end
    // second request while one is pending is refused
    wr(4'h7, 1);
    wr(4'h7, 1);
    rd(4'h5, PEIR_USR_WAIT);
    wait_msg();
    rd(4'h2, 3);
    @(posedge clk_i);
    auto_status_en_i <= 1'b0;
    for (int s = 1; s >= 0; s--) begin
      wr(4'h0, 32'(s) << 9);
      rd(4'h0, 32'(s) << 9);
      repeat (4) @(posedge clk_i);
      #1;
      chk("status", s, int_status_o);
    end
    $display("test overrun and status done");
    print_verdict();
  end
endmodule
`default_nettype wire
